// File: pei_pkg.sv
// shared constants and types for the bus-line pin edge interrupt block
// assumes one 250 MHz clock and a 32-bit Avalon-MM register bus
package pei_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // register byte offsets, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_PORT3_LATCH = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RISE_EN     = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FALL_EN     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_LOW   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_HIGH  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK_LOW    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK_HIGH   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EVT_STATUS  = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_EVT_MASK    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PORT3_MODE  = 8'h24;

  // field positions
  localparam int unsigned CLK_LATCH_BIT  = 3;
  localparam int unsigned DATA_LATCH_BIT = 2;
  localparam int unsigned CLK_EDGE_BIT   = 5;
  localparam int unsigned DATA_EDGE_BIT  = 6;
  localparam int unsigned CLK_FLAG_BIT   = 7;  // in low flag and low mask registers
  localparam int unsigned DATA_FLAG_BIT  = 0;  // in high flag and high mask registers
  localparam int unsigned EVT_CLK_BIT    = 0;
  localparam int unsigned EVT_DATA_BIT   = 1;
  localparam int unsigned EVT_W          = 2;

  // fixed-zero bits of the high flag register and used port latch bits
  localparam logic [REG_W-1:0] FLAGS_HIGH_ZERO = 8'h18;
  localparam logic [REG_W-1:0] PORT3_USED      = 8'h0f;

  // reset values
  localparam logic [REG_W-1:0]  RST_LATCH = 8'h00;
  localparam logic [REG_W-1:0]  RST_EDGE  = 8'h00;
  localparam logic [REG_W-1:0]  RST_FLAGS = 8'h00;
  localparam logic [REG_W-1:0]  RST_MASK  = 8'hff;
  localparam logic [REG_W-1:0]  RST_MODE  = 8'hff;
  localparam logic [EVT_W-1:0]  RST_EVT   = 2'h0;
  localparam logic [EVT_W-1:0]  RST_EVMSK = 2'h3;
  localparam logic [DATA_W-1:0] RD_ZERO   = 32'h0000_0000;

  // the two bus lines travel together
  typedef struct packed {
    logic scl;
    logic sda;
  } pei_lines_type;

  localparam pei_lines_type LINES_IDLE = '{scl: 1'b1, sda: 1'b1};

endpackage

// File: pei_top.sv
// pin edge interrupt logic for the clock and data lines of a software bus slave
// assumes an Avalon-MM master on ref_clk and open-drain bus pins outside
//
// Behaviour
// - port latch bits 3 to 0 store the written value, bits 7 to 4 stay 0; init clears bits 3 and 2
// - clock-edge mask at 1 blocks service of clock requests; 0 allows it
// - rising/falling enable pair: 00 none, 01 falling, 10 rising, 11 both
// - clock-line input is set to rising edges only
// - data-line input is set to both edges for start and stop detection
// - request flag reads 1 once a request was generated, else 0
// - after edge setup both request flags are cleared to 0
// - init ends by unmasking data-line requests; clock stays masked
// - port reads of bits 3 and 2 return the clock and data pin levels
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pei_top
  import pei_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [DATA_W-1:0]   avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [DATA_W-1:0]   avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic                scl_i,
  output logic                     scl_o,
  output logic                     scl_oe_n,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe_n,
  output logic                     clock_line_edge_interrupt,
  output logic                     data_line_edge_interrupt,
  output logic                     irq
);

  // true when an edge of the given direction is enabled by the bit pair
  function automatic logic edge_valid(input logic prev,
                                      input logic cur,
                                      input logic rise_en,
                                      input logic fall_en);
    edge_valid = (rise_en & ~prev & cur) | (fall_en & prev & ~cur);
  endfunction

  // accepted write to one register, low byte lane only carries data
  function automatic logic wr_hit(input logic              acc,
                                  input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] ofs);
    wr_hit = acc & (addr == ofs);
  endfunction

  logic                 ack_r;
  logic                 wr_acc;
  logic                 rd_acc;
  logic [REG_W-1:0]     wbyte;
  logic [REG_W-1:0]     port3_output_latch_r;
  logic [REG_W-1:0]     port3_mode_r;
  logic [REG_W-1:0]     ext_int_rising_enable_r;
  logic [REG_W-1:0]     ext_int_falling_enable_r;
  logic [REG_W-1:0]     int_request_flags_low_r;
  logic [REG_W-1:0]     int_request_flags_high_r;
  logic [REG_W-1:0]     int_mask_flags_low_r;
  logic [REG_W-1:0]     int_mask_flags_high_r;
  logic [EVT_W-1:0]     evt_status_r;
  logic [EVT_W-1:0]     evt_mask_r;
  logic [EVT_W-1:0]     evt_set;
  pei_lines_type        sync1_r;
  pei_lines_type        sync2_r;
  pei_lines_type        sync3_r;
  pei_lines_type        level_r;
  pei_lines_type        level_prev_r;
  logic                 clk_edge;
  logic                 data_edge;
  logic                 clock_edge_request_flag;
  logic                 data_edge_request_flag;
  logic                 clock_edge_int_mask;
  logic                 data_edge_int_mask;
  logic [DATA_W-1:0]    rd_mux;

  // one wait cycle per access: the answer edge is the second one after the request appears
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_acc          = avs_write & ack_r & avs_byteenable[0];
  assign rd_acc          = avs_read & ~ack_r;
  assign wbyte           = avs_writedata[REG_W-1:0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // pin inputs: three stages; a level counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= LINES_IDLE;
      sync2_r <= LINES_IDLE;
      sync3_r <= LINES_IDLE;
    end else begin
      sync1_r <= '{scl: scl_i, sda: sda_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // filtered levels; a one-cycle glitch never reaches the edge logic
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_r      <= LINES_IDLE;
      level_prev_r <= LINES_IDLE;
    end else begin
      if (sync2_r.scl == sync3_r.scl) begin
        level_r.scl <= sync3_r.scl;
      end
      if (sync2_r.sda == sync3_r.sda) begin
        level_r.sda <= sync3_r.sda;
      end
      level_prev_r <= level_r;
    end
  end

  // edge selection per input from the enable pairs
  assign clk_edge  = edge_valid(level_prev_r.scl, level_r.scl,
                                ext_int_rising_enable_r[CLK_EDGE_BIT],
                                ext_int_falling_enable_r[CLK_EDGE_BIT]);
  assign data_edge = edge_valid(level_prev_r.sda, level_r.sda,
                                ext_int_rising_enable_r[DATA_EDGE_BIT],
                                ext_int_falling_enable_r[DATA_EDGE_BIT]);

  // port output latch and pin mode; latch drives the pins while mode bit is 0
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port3_output_latch_r <= RST_LATCH;
      port3_mode_r         <= RST_MODE;
    end else begin
      if (wr_hit(wr_acc, avs_address, OFS_PORT3_LATCH)) begin
        port3_output_latch_r <= wbyte & PORT3_USED;
      end
      if (wr_hit(wr_acc, avs_address, OFS_PORT3_MODE)) begin
        port3_mode_r <= wbyte;
      end
    end
  end

  // open drain use: software clears the latch once and toggles the mode bit
  assign scl_o    = port3_output_latch_r[CLK_LATCH_BIT];
  assign sda_o    = port3_output_latch_r[DATA_LATCH_BIT];
  assign scl_oe_n = port3_mode_r[CLK_LATCH_BIT];
  assign sda_oe_n = port3_mode_r[DATA_LATCH_BIT];

  // edge enable registers, configured by software for each input
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_int_rising_enable_r  <= RST_EDGE;
      ext_int_falling_enable_r <= RST_EDGE;
    end else begin
      if (wr_hit(wr_acc, avs_address, OFS_RISE_EN)) begin
        ext_int_rising_enable_r <= wbyte;
      end
      if (wr_hit(wr_acc, avs_address, OFS_FALL_EN)) begin
        ext_int_falling_enable_r <= wbyte;
      end
    end
  end

  // request flags: written value is stored, high register bits 4 and 3 forced to 0, but a same-cycle edge wins over a clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_request_flags_low_r  <= RST_FLAGS;
      int_request_flags_high_r <= RST_FLAGS;
    end else begin
      if (wr_hit(wr_acc, avs_address, OFS_FLAGS_LOW)) begin
        int_request_flags_low_r <= wbyte;
      end
      if (clk_edge) begin
        int_request_flags_low_r[CLK_FLAG_BIT] <= 1'b1;
      end
      if (wr_hit(wr_acc, avs_address, OFS_FLAGS_HIGH)) begin
        int_request_flags_high_r <= wbyte & ~FLAGS_HIGH_ZERO;
      end
      if (data_edge) begin
        int_request_flags_high_r[DATA_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // mask registers; reset leaves every source masked until software opens it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_mask_flags_low_r  <= RST_MASK;
      int_mask_flags_high_r <= RST_MASK;
    end else begin
      if (wr_hit(wr_acc, avs_address, OFS_MASK_LOW)) begin
        int_mask_flags_low_r <= wbyte;
      end
      if (wr_hit(wr_acc, avs_address, OFS_MASK_HIGH)) begin
        int_mask_flags_high_r <= wbyte;
      end
    end
  end

  assign clock_edge_request_flag = int_request_flags_low_r[CLK_FLAG_BIT];
  assign data_edge_request_flag  = int_request_flags_high_r[DATA_FLAG_BIT];
  assign clock_edge_int_mask     = int_mask_flags_low_r[CLK_FLAG_BIT];
  assign data_edge_int_mask      = int_mask_flags_high_r[DATA_FLAG_BIT];

  // service requests: flag held independent of mask, mask only gates the request
  assign clock_line_edge_interrupt = clock_edge_request_flag & ~clock_edge_int_mask;
  assign data_line_edge_interrupt  = data_edge_request_flag & ~data_edge_int_mask;

  // sticky event status, write one to clear, edge in the same cycle wins
  assign evt_set[EVT_CLK_BIT]  = clk_edge;
  assign evt_set[EVT_DATA_BIT] = data_edge;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_status_r <= RST_EVT;
      evt_mask_r   <= RST_EVMSK;
    end else begin
      if (wr_hit(wr_acc, avs_address, OFS_EVT_STATUS)) begin
        evt_status_r <= (evt_status_r & ~wbyte[EVT_W-1:0]) | evt_set;
      end else begin
        evt_status_r <= evt_status_r | evt_set;
      end
      if (wr_hit(wr_acc, avs_address, OFS_EVT_MASK)) begin
        evt_mask_r <= wbyte[EVT_W-1:0];
      end
    end
  end

  // level interrupt: a mask bit of 1 blocks its status bit
  assign irq = |(evt_status_r & ~evt_mask_r);

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_mux = RD_ZERO;
    unique case (avs_address)
      OFS_PORT3_LATCH: begin
        rd_mux[REG_W-1:0] = port3_output_latch_r & PORT3_USED;
        rd_mux[CLK_LATCH_BIT]  = level_r.scl;
        rd_mux[DATA_LATCH_BIT] = level_r.sda;
      end
      OFS_RISE_EN:    rd_mux[REG_W-1:0] = ext_int_rising_enable_r;
      OFS_FALL_EN:    rd_mux[REG_W-1:0] = ext_int_falling_enable_r;
      OFS_FLAGS_LOW:  rd_mux[REG_W-1:0] = int_request_flags_low_r;
      OFS_FLAGS_HIGH: rd_mux[REG_W-1:0] = int_request_flags_high_r;
      OFS_MASK_LOW:   rd_mux[REG_W-1:0] = int_mask_flags_low_r;
      OFS_MASK_HIGH:  rd_mux[REG_W-1:0] = int_mask_flags_high_r;
      OFS_EVT_STATUS: rd_mux[EVT_W-1:0] = evt_status_r;
      OFS_EVT_MASK:   rd_mux[EVT_W-1:0] = evt_mask_r;
      OFS_PORT3_MODE: rd_mux[REG_W-1:0] = port3_mode_r;
      default:        rd_mux = RD_ZERO;
    endcase
  end

  // read data captured in the wait cycle, so it stands at the answer edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= RD_ZERO;
    end else if (rd_acc) begin
      avs_readdata <= rd_mux;
    end
  end

  // the init order (latch clear, clock mask, edges, flag clear, data unmask)
  // is software's; hardware keeps every step independent so any order is safe

endmodule

`default_nettype wire

// File: pei_top_asserts.sv
// checker for the pin edge interrupt block, bound to its top module
// assumes one clock ref_clk and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module pei_top_asserts
  import pei_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic              scl_i,
  input wire logic              sda_i,
  input wire logic              scl_o,
  input wire logic              sda_o,
  input wire logic              clock_line_edge_interrupt,
  input wire logic              data_line_edge_interrupt
);
  // request seen, and an accepted write to the port latch
  wire logic req = avs_read | avs_write;
  wire logic lwr = avs_write & ~avs_waitrequest & avs_byteenable[0]
                   & (avs_address == OFS_PORT3_LATCH);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_WAIT_FIRST: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("new request got no wait cycle");
  AST_WAIT_ONE: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait lasted more than one cycle");
  AST_IDLE_NO_WAIT: assert property (!req |-> !avs_waitrequest)
    else $error("wait raised without a request");
  AST_LATCH_WRITE: assert property (lwr |=>
    scl_o == $past(avs_writedata[CLK_LATCH_BIT])
    && sda_o == $past(avs_writedata[DATA_LATCH_BIT]))
    else $error("latch outputs do not follow write");
  AST_LATCH_HOLD: assert property (!lwr |=> $stable(scl_o) && $stable(sda_o))
    else $error("latch outputs moved without write");
  // pins settle through the synchronizer long before the capture
  AST_PORT_READ: assert property (($stable(scl_i) && $stable(sda_i))[*6]
    ##1 (avs_read && !avs_waitrequest && avs_address == OFS_PORT3_LATCH)
    |-> avs_readdata[3] == $past(scl_i)
    && avs_readdata[2] == $past(sda_i) && avs_readdata[7:4] == 4'h0)
    else $error("port read does not show pin levels");
  AST_READ_STANDS: assert property (
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  AST_CLK_INT_HOLD: assert property ($fell(clock_line_edge_interrupt)
    |-> $past(avs_write) && !$past(avs_waitrequest))
    else $error("clock interrupt dropped without write");
  AST_DATA_INT_HOLD: assert property ($fell(data_line_edge_interrupt)
    |-> $past(avs_write) && !$past(avs_waitrequest))
    else $error("data interrupt dropped without write");
endmodule
bind pei_top pei_top_asserts pei_top_asserts_inst (.ref_clk(ref_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .sda_o(sda_o),
  .clock_line_edge_interrupt(clock_line_edge_interrupt),
  .data_line_edge_interrupt(data_line_edge_interrupt));
`default_nettype wire

// File: pei_bus_master.sv
// far-side bus master model driving the clock and data lines
// assumes pulled-up open-drain lines; a released line reads high
`timescale 1ns/1ps
`default_nettype none
module pei_bus_master (
  input  wire logic ref_clk,
  output logic      scl_m,
  output logic      sda_m
);
  // lines idle high and stand still between calls, no free-running clock
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic drive(input logic s, input logic d);
    @(posedge ref_clk);
    scl_m <= s;
    sda_m <= d;
  endtask
endmodule
`default_nettype wire

// File: pei_top_tb_top.sv
// self-checking bench for the pin edge interrupt block with a register model
// assumes the bus master model and the block both pull the lines low, as open drain
`timescale 1ns/1ps
`default_nettype none
module pei_top_tb_top;
  import pei_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = 8'h00;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = 32'h0000_0000;
  logic [3:0]        avs_byteenable = 4'h0;
  logic [DATA_W-1:0] avs_readdata, rdat, r;
  logic              avs_waitrequest, scl_o, sda_o, scl_oe_n, sda_oe_n, c_int, d_int, irq;
  logic              scl_m, sda_m, e_scl = 1'b1, e_sda = 1'b1;
  wire logic         scl_w, sda_w;
  int                err_count = 0, cmp_count = 0, m[int], k;
  logic [7:0]        ofs[10] = '{OFS_PORT3_LATCH, OFS_RISE_EN, OFS_FALL_EN, OFS_FLAGS_LOW,
    OFS_FLAGS_HIGH, OFS_MASK_LOW, OFS_MASK_HIGH, OFS_EVT_STATUS, OFS_EVT_MASK, OFS_PORT3_MODE};
  int                rv[10] = '{0, 0, 0, 0, 0, 8'hff, 8'hff, 0, 3, 8'hff};
  logic [1:0]        st[4] = '{2'h1, 2'h3, 2'h2, 2'h3};
  always #2 ref_clk = ~ref_clk;
  // a line is low if the master or the block pulls it
  assign scl_w = scl_m & (scl_oe_n | scl_o);
  assign sda_w = sda_m & (sda_oe_n | sda_o);
  pei_top pei_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .clock_line_edge_interrupt(c_int),
    .data_line_edge_interrupt(d_int), .irq(irq));
  pei_bus_master pei_bus_master_inst (.ref_clk(ref_clk), .scl_m(scl_m), .sda_m(sda_m));
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_w({31'h0, got}, {31'h0, exp});
  endtask
  // one access: hold until waitrequest is seen low, then release; model follows writes
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    // waitrequest and read data are looked at in the edge's own time step, before
    // the design's updates land, so they are what the slave shows at that edge
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk_b(1'b1, 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    #1;
    if (wr && be[0] && a == OFS_EVT_STATUS) m[a] = m[a] & ~int'(d[1:0]);
    else if (wr && be[0] && m.exists(a)) m[a] = int'(d[7:0]);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [31:0] e;
    xfer(a, 1'b0, 32'h0000_0000, 4'h0);
    e = m.exists(a) ? m[a] : 0;
    if (a == OFS_PORT3_LATCH) e = {28'h0, e_scl, e_sda, e[1:0]};
    if (a == OFS_FLAGS_HIGH) e = e & ~{24'h0, FLAGS_HIGH_ZERO};
    chk_w(rdat, e);
  endtask
  task automatic ints();
    chk_b(c_int, m[OFS_FLAGS_LOW][7] & !m[OFS_MASK_LOW][7]);
    chk_b(d_int, m[OFS_FLAGS_HIGH][0] & !m[OFS_MASK_HIGH][0]);
  endtask
  // move the lines, record valid edges in the model, wait out the synchronizer
  task automatic lines(input logic s, input logic d);
    if (s != e_scl && (s ? m[OFS_RISE_EN][5] : m[OFS_FALL_EN][5])) begin
      m[OFS_FLAGS_LOW][7] = 1;
      m[OFS_EVT_STATUS][0] = 1;
    end
    if (d != e_sda && (d ? m[OFS_RISE_EN][6] : m[OFS_FALL_EN][6])) begin
      m[OFS_FLAGS_HIGH][0] = 1;
      m[OFS_EVT_STATUS][1] = 1;
    end
    e_scl = s;
    e_sda = d;
    pei_bus_master_inst.drive(s, d);
    repeat (8 + $urandom_range(3)) @(posedge ref_clk);
    #1;
    ints();
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200_000;
    err_count++;
    print_verdict();
  end
  initial begin
    r = $urandom(96357);
    foreach (ofs[i]) m[ofs[i]] = rv[i];
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (ofs[i]) rd(ofs[i]);
    rd(8'h40);
    // initialisation in its documented order
    wr(OFS_PORT3_LATCH, 32'h0000_0000);
    wr(OFS_MASK_LOW, 32'h0000_00ff);
    wr(OFS_RISE_EN, 32'h0000_0060);
    wr(OFS_FALL_EN, 32'h0000_0040);
    wr(OFS_FLAGS_LOW, 32'h0000_0000);
    wr(OFS_FLAGS_HIGH, 32'h0000_0000);
    wr(OFS_MASK_HIGH, 32'h0000_00fe);
    foreach (ofs[i]) rd(ofs[i]);
    repeat (4) begin
      r = $urandom;
      wr(OFS_PORT3_LATCH, r & 32'h0000_00ff);
      chk_b(scl_o, r[3]);
      chk_b(sda_o, r[2]);
      rd(OFS_PORT3_LATCH);
    end
    // lane 0 disabled and unmapped writes leave registers alone
    xfer(OFS_RISE_EN, 1'b1, 32'h0000_00ff, 4'he);
    wr(8'h40, 32'h0000_00ff);
    rd(OFS_RISE_EN);
    // every edge code on both lines, each single edge on its own
    for (k = 0; k < 4; k++) begin
      wr(OFS_RISE_EN, k[1] ? 32'h0000_0060 : 32'h0000_0000);
      wr(OFS_FALL_EN, k[0] ? 32'h0000_0060 : 32'h0000_0000);
      foreach (st[j]) begin
        lines(st[j][1], st[j][0]);
        rd(OFS_FLAGS_LOW);
        rd(OFS_FLAGS_HIGH);
        wr(OFS_FLAGS_LOW, 32'h0000_0000);
        wr(OFS_FLAGS_HIGH, 32'h0000_0000);
      end
    end
    // a full frame with clock masked and data unmasked
    wr(OFS_RISE_EN, 32'h0000_0060);
    wr(OFS_FALL_EN, 32'h0000_0040);
    lines(1'b1, 1'b0);
    for (k = 0; k < 9; k++) begin
      r = $urandom;
      lines(1'b0, e_sda);
      lines(1'b0, r[0]);
      lines(1'b1, r[0]);
    end
    lines(1'b0, 1'b0);
    lines(1'b1, 1'b0);
    lines(1'b1, 1'b1);
    rd(OFS_FLAGS_LOW);
    wr(OFS_MASK_LOW, 32'h0000_007f);
    ints();
    wr(OFS_MASK_LOW, 32'h0000_00ff);
    ints();
    rd(OFS_FLAGS_LOW);
    wr(OFS_FLAGS_LOW, 32'h0000_0000);
    wr(OFS_FLAGS_HIGH, 32'h0000_0000);
    ints();
    // event status, its mask and the summary interrupt
    wr(OFS_EVT_STATUS, 32'h0000_0003);
    lines(1'b0, 1'b1);
    lines(1'b1, 1'b1);
    chk_b(irq, 1'b0);
    rd(OFS_EVT_STATUS);
    wr(OFS_EVT_MASK, 32'h0000_0000);
    chk_b(irq, 1'b1);
    wr(OFS_EVT_STATUS, 32'h0000_0001);
    chk_b(irq, 1'b0);
    rd(OFS_EVT_STATUS);
    // the block pulls both lines low itself: enables, pin readback, data edge
    wr(OFS_PORT3_LATCH, 32'h0000_0000);
    wr(OFS_PORT3_MODE, 32'h0000_00f3);
    chk_b(scl_oe_n, 1'b0);
    chk_b(sda_oe_n, 1'b0);
    lines(1'b0, 1'b0);
    rd(OFS_PORT3_LATCH);
    rd(OFS_PORT3_MODE);
    rd(OFS_EVT_STATUS);
    chk_b(irq, |(m[OFS_EVT_STATUS][1:0] & ~m[OFS_EVT_MASK][1:0]));
    print_verdict();
  end
endmodule
`default_nettype wire
